/* File: rtl/aalu_consts.svh */
// Constants for the add and logic ALU block
`ifndef AALU_CONSTS_SVH
`define AALU_CONSTS_SVH
`define AALU_ACCUM_RST  8'h00
`define AALU_MEM_RST    8'h00
`define AALU_FLAG_RST   1'b0
`define AALU_MSB        7
`define AALU_NIB_MSB    3
`define AALU_OP_W       3
`endif

/* File: rtl/aalu_pkg.sv */
// Types for the add and logic ALU block
`include "aalu_consts.svh"
package aalu_pkg;
  typedef enum logic [2:0] {
    AALU_OP_ADC_A   = 3'h0,
    AALU_OP_ADC_MEM = 3'h1,
    AALU_OP_ADD_A   = 3'h2,
    AALU_OP_ADD_IMM = 3'h3,
    AALU_OP_ADD_MEM = 3'h4,
    AALU_OP_AND_A   = 3'h5,
    AALU_OP_AND_IMM = 3'h6,
    AALU_OP_AND_MEM = 3'h7
  } aalu_op_t;
  typedef enum logic [1:0] {
    AALU_ST_IDLE = 2'h1,
    AALU_ST_DONE = 2'h2
  } aalu_state_t;
endpackage

/* File: rtl/aalu_adder.sv */
// Eight-bit adder with carry in, producing the carry, half-carry and overflow flags
`timescale 1ns/1ps
`default_nettype none
module aalu_adder
  import aalu_pkg::*;
(
  // Operands
  input  wire logic [7:0] a,
  input  wire logic [7:0] b,
  input  wire logic       cin,
  // Results
  output logic [7:0]      sum,
  output logic            carry_out,
  output logic            half_carry_out,
  output logic            overflow_out
);
  logic [4:0] low_nib;
  logic [8:0] full;
  always_comb begin
    low_nib        = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    full           = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    sum            = full[7:0];
    carry_out      = full[8];
    half_carry_out = low_nib[4];
    // Same-sign operands with a result of the other sign
    overflow_out   = (a[7] == b[7]) && (full[7] != a[7]);
  end
endmodule
`default_nettype wire

/* File: rtl/aalu_core.sv */
// Add, add-with-carry and AND datapath with accumulator and flags
`timescale 1ns/1ps
`default_nettype none
`include "aalu_consts.svh"
module aalu_core
  import aalu_pkg::*;
(
  // Clock and reset
  input  wire logic       core_clk,
  input  wire logic       rst,
  // Operation request
  input  wire logic       op_valid,
  input  wire logic [2:0] op_code,
  input  wire logic [7:0] mem_operand,
  input  wire logic [7:0] imm_operand,
  // Accumulator load
  input  wire logic       accum_load,
  input  wire logic [7:0] accum_load_data,
  // Memory write-back
  output logic            mem_write,
  output logic [7:0]      mem_write_data,
  // State
  output logic [7:0]      accumulator_reg,
  output logic            carry_flag,
  output logic            half_carry_flag,
  output logic            zero_flag,
  output logic            signed_overflow_flag,
  output logic            op_done
);
  aalu_op_t    op;
  aalu_state_t state_r;
  aalu_state_t state_nxt;
  logic [7:0]  add_b;
  logic        add_cin;
  logic [7:0]  add_sum;
  logic        add_c;
  logic        add_hc;
  logic        add_ov;
  logic [7:0]  result;
  logic        is_add;
  logic        to_mem;

  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  assign op = aalu_op_t'(op_code);

  // Every item sets all four controls, so no stale value can leak through
  always_comb begin
    add_b   = mem_operand;
    add_cin = 1'b0;
    is_add  = 1'b1;
    to_mem  = 1'b0;
    case (op)
      AALU_OP_ADC_A: begin
        add_b   = mem_operand;
        add_cin = carry_flag;
        is_add  = 1'b1;
        to_mem  = 1'b0;
      end
      AALU_OP_ADC_MEM: begin
        add_b   = mem_operand;
        add_cin = carry_flag;
        is_add  = 1'b1;
        to_mem  = 1'b1;
      end
      AALU_OP_ADD_A: begin
        add_b   = mem_operand;
        add_cin = 1'b0;
        is_add  = 1'b1;
        to_mem  = 1'b0;
      end
      AALU_OP_ADD_IMM: begin
        add_b   = imm_operand;
        add_cin = 1'b0;
        is_add  = 1'b1;
        to_mem  = 1'b0;
      end
      AALU_OP_ADD_MEM: begin
        add_b   = mem_operand;
        add_cin = 1'b0;
        is_add  = 1'b1;
        to_mem  = 1'b1;
      end
      AALU_OP_AND_A: begin
        add_b   = mem_operand;
        add_cin = 1'b0;
        is_add  = 1'b0;
        to_mem  = 1'b0;
      end
      AALU_OP_AND_IMM: begin
        add_b   = imm_operand;
        add_cin = 1'b0;
        is_add  = 1'b0;
        to_mem  = 1'b0;
      end
      AALU_OP_AND_MEM: begin
        add_b   = mem_operand;
        add_cin = 1'b0;
        is_add  = 1'b0;
        to_mem  = 1'b1;
      end
      default: begin
        add_b   = mem_operand;
        add_cin = 1'b0;
        is_add  = 1'b1;
        to_mem  = 1'b0;
      end
    endcase
  end

  aalu_adder u_adder (
    .a              (accumulator_reg),
    .b              (add_b),
    .cin            (add_cin),
    .sum            (add_sum),
    .carry_out      (add_c),
    .half_carry_out (add_hc),
    .overflow_out   (add_ov)
  );

  assign result = is_add ? add_sum : (accumulator_reg & add_b);

  // One operation per cycle; done pulse follows each taken request
  always_comb begin
    case (state_r)
      AALU_ST_IDLE: state_nxt = op_valid ? AALU_ST_DONE : AALU_ST_IDLE;
      AALU_ST_DONE: state_nxt = op_valid ? AALU_ST_DONE : AALU_ST_IDLE;
      default:      state_nxt = AALU_ST_IDLE;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r <= AALU_ST_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // Done is a plain one-cycle echo of the request, never held
  always_ff @(posedge core_clk) begin
    if (rst) begin
      op_done <= 1'b0;
    end else begin
      op_done <= op_valid;
    end
  end

  // Accumulator: an operation that writes the accumulator wins over a plain load in the same cycle; a memory-targeted one lets the load through
  always_ff @(posedge core_clk) begin
    if (rst) begin
      accumulator_reg <= `AALU_ACCUM_RST;
    end else if (op_valid && !to_mem) begin
      accumulator_reg <= result;
    end else if (accum_load) begin
      accumulator_reg <= accum_load_data;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_write <= 1'b0;
    end else begin
      mem_write <= op_valid && to_mem;
    end
  end

  // Write data holds after the strobe so a slow memory port can sample late
  always_ff @(posedge core_clk) begin
    if (rst) begin
      mem_write_data <= `AALU_MEM_RST;
    end else if (op_valid && to_mem) begin
      mem_write_data <= result;
    end
  end

  // AND ops leave carry, half-carry and overflow untouched
  always_ff @(posedge core_clk) begin
    if (rst) begin
      carry_flag <= `AALU_FLAG_RST;
    end else if (op_valid && is_add) begin
      carry_flag <= add_c;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      half_carry_flag <= `AALU_FLAG_RST;
    end else if (op_valid && is_add) begin
      half_carry_flag <= add_hc;
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      signed_overflow_flag <= `AALU_FLAG_RST;
    end else if (op_valid && is_add) begin
      signed_overflow_flag <= add_ov;
    end
  end

  // Zero follows every operation, add or AND alike
  always_ff @(posedge core_clk) begin
    if (rst) begin
      zero_flag <= `AALU_FLAG_RST;
    end else if (op_valid) begin
      zero_flag <= is_zero(result);
    end
  end
endmodule
`default_nettype wire

/* File: sim/aalu_core_sva.sv */
// Port-level checks for the add and logic ALU core
`timescale 1ns/1ps
`default_nettype none
module aalu_core_sva (
  // Clock, reset and requests
  input wire logic       core_clk, rst, op_valid, accum_load,
  input wire logic [2:0] op_code,
  input wire logic [7:0] mem_operand, imm_operand, accum_load_data,
  // Results
  input wire logic       mem_write, carry_flag, half_carry_flag,
  input wire logic       zero_flag, signed_overflow_flag, op_done,
  input wire logic [7:0] mem_write_data, accumulator_reg
);
  logic [7:0] go, b, n, s;
  logic [3:0] hs;
  logic       co, hc, ci, ov, z;
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  assign go = {7'h00, op_valid} << op_code;
  assign b = (op_code == 3'h3 || op_code == 3'h6) ? imm_operand : mem_operand;
  assign ci = op_code < 3'h2 ? carry_flag : 1'h0;
  assign {co, s} = 9'(accumulator_reg) + 9'(b) + 9'(ci);
  assign {hc, hs} = 5'(accumulator_reg[3:0]) + 5'(b[3:0]) + 5'(ci);
  assign n = accumulator_reg & b;
  assign ov = accumulator_reg[7] == b[7] && s[7] != b[7];
  assign z = (op_code > 3'h4 ? n : s) == 8'h00;
  AST_ADC_ACCUM: assert property (go[0] |=> accumulator_reg == $past(s))
    else $error("adc to accumulator result wrong");
  AST_ADC_MEM: assert property (go[1] |=> mem_write && mem_write_data == $past(s))
    else $error("adc to mem result wrong");
  AST_ADD_ACCUM: assert property (go[2] || go[3] |=> accumulator_reg == $past(s))
    else $error("add to accumulator result wrong");
  AST_ADD_MEM: assert property (go[4] |=> mem_write && mem_write_data == $past(s))
    else $error("add to mem result wrong");
  AST_AND_ACCUM: assert property (go[5] || go[6] |=> accumulator_reg == $past(n)
    && $stable({carry_flag, half_carry_flag, signed_overflow_flag}))
    else $error("and to accumulator wrong");
  AST_IDLE_QUIET: assert property (!op_valid |=> !op_done && !mem_write)
    else $error("pulse without request");
  AST_AND_MEM: assert property (go[7] |=> mem_write && mem_write_data == $past(n) && $stable(carry_flag))
    else $error("and to mem wrong");
  AST_CARRY: assert property (op_valid && op_code < 3'h5 |=> carry_flag == $past(co) && half_carry_flag == $past(hc))
    else $error("carry flags wrong");
  AST_ZERO: assert property (op_valid |=> op_done && zero_flag == $past(z))
    else $error("zero flag wrong");
  AST_OVF: assert property (op_valid && op_code < 3'h5 |=> signed_overflow_flag == $past(ov))
    else $error("overflow flag wrong");
endmodule
`default_nettype wire

/* File: sim/test_add_and_logic_alu_ops.sv */
// Directed bench for the add and logic ALU core
`timescale 1ns/1ps
`default_nettype none
module test_add_and_logic_alu_ops;
  logic       core_clk = 0, rst = 1, op_valid = 0, accum_load = 0;
  logic [2:0] op_code = 3'h0;
  logic [7:0] mem_operand = 8'h00, imm_operand = 8'h00, accum_load_data = 8'h00;
  logic       mem_write, carry_flag, half_carry_flag, zero_flag;
  logic       signed_overflow_flag, op_done;
  logic [7:0] mem_write_data, accumulator_reg, e_a = 8'h00, e_m = 8'h00;
  logic [3:0] e_f = 4'h0, flg;
  logic [7:0] av[3] = '{8'h7F, 8'h80, 8'h0F};
  logic [7:0] mv[3] = '{8'h01, 8'h80, 8'hF1};
  logic [7:0] iv[3] = '{8'h81, 8'hFF, 8'hF0};
  int         n_mismatch = 0, n_checks = 0;
  always #50 core_clk = ~core_clk;
  assign flg = {signed_overflow_flag, zero_flag, half_carry_flag, carry_flag};
  aalu_core i_dut (
    .core_clk(core_clk), .rst(rst), .op_valid(op_valid), .op_code(op_code),
    .mem_operand(mem_operand), .imm_operand(imm_operand),
    .accum_load(accum_load), .accum_load_data(accum_load_data),
    .mem_write(mem_write), .mem_write_data(mem_write_data),
    .accumulator_reg(accumulator_reg), .carry_flag(carry_flag),
    .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
    .signed_overflow_flag(signed_overflow_flag), .op_done(op_done));
  task automatic chk(string nm, logic [23:0] e, logic [23:0] g);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic load(logic [7:0] a);
    op_valid = 0;
    accum_load = 1;
    accum_load_data = a;
    @(negedge core_clk);
    accum_load = 0;
    e_a = a;
  endtask
  // Model is updated before driving, so back-to-back calls chain the carry
  task automatic run(logic [2:0] c, logic [7:0] m, logic [7:0] i);
    logic [7:0] b, r;
    logic       co, hc, ci, mw;
    b = (c == 3'h3 || c == 3'h6) ? i : m;
    ci = c < 3'h2 && e_f[0];
    {co, r} = 9'(e_a) + 9'(b) + 9'(ci);
    hc = (5'(e_a[3:0]) + 5'(b[3:0]) + 5'(ci)) > 5'h0F;
    if (c < 3'h5) e_f = {e_a[7] == b[7] && r[7] != b[7], 1'h0, hc, co};
    else r = e_a & b;
    e_f[2] = r == 8'h00;
    mw = c == 3'h1 || c == 3'h4 || c == 3'h7;
    if (mw) e_m = r;
    else e_a = r;
    op_valid = 1;
    op_code = c;
    mem_operand = m;
    imm_operand = i;
    @(negedge core_clk);
    chk("accumulator", e_a, accumulator_reg);
    chk("flags", e_f, flg);
    chk("mem", {mw, e_m}, {mem_write, mem_write_data});
    chk("done", 1, op_done);
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #100000;
    n_mismatch++;
    print_verdict;
  end
  initial begin
    repeat (4) @(negedge core_clk);
    rst = 0;
    load(8'hFF);
    run(3'h1, 8'h01, 8'h00);
    run(3'h0, 8'h00, 8'h00);
    $display("carry chain test done");
    for (int k = 0; k < 3; k++) begin
      for (int c = 0; c < 8; c++) begin
        load(av[k]);
        run(3'(c), mv[k], iv[k]);
      end
      $display("operation table row %0d done", k);
    end
    print_verdict;
  end
endmodule
bind aalu_core aalu_core_sva i_sva (
  .core_clk(core_clk), .rst(rst), .op_valid(op_valid),
  .accum_load(accum_load), .op_code(op_code), .mem_operand(mem_operand),
  .imm_operand(imm_operand), .accum_load_data(accum_load_data),
  .mem_write(mem_write), .carry_flag(carry_flag),
  .half_carry_flag(half_carry_flag), .zero_flag(zero_flag),
  .signed_overflow_flag(signed_overflow_flag), .op_done(op_done),
  .mem_write_data(mem_write_data), .accumulator_reg(accumulator_reg));
`default_nettype wire
